// ---- verification/etc_analyzer_model.sv ----
// Behavioural logic analyzer that probes the trace pins in the middle of each core clock cycle.
`timescale 1ns/1ps
`default_nettype none
module etc_analyzer_model (
    input  wire logic                    sys_clk,
    input  wire logic                    rst_b,
    input  wire etc_pkg::etc_trace_bus_t tracePins,
    input  wire logic                    traceOutEn,
    output etc_pkg::etc_trace_bus_t      sample,
    output logic [15:0]                  clkEdges
);
    import etc_pkg::*;

    // The probe samples on the falling edge so that it never races the core's launching edge.
    always_ff @(negedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            sample   <= '0;
            clkEdges <= 16'h0000;
        end else if (traceOutEn) begin
            sample <= tracePins;
            if (tracePins.traceClockPin !== sample.traceClockPin) begin
                clkEdges <= clkEdges + 16'h0001;
            end
        end
    end
endmodule
`default_nettype wire

// ---- verification/testbench.sv ----
// Self-checking bench for the trace core in State 2x, State 1x falling-edge and Timing builds.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import etc_pkg::*;

    logic                        sys_clk;
    logic                        rst_b;
    etc_ctrl_link_t              ctrlLink;
    logic [BANK_COUNT-1:0][15:0] bankData;
    logic [BANK_COUNT-1:0][8:0]  bankDataT;
    logic [BANK_COUNT-1:0][7:0]  bankDataF;
    etc_trace_bus_t              tracePins, tracePinsN, tPinsT, tPinsTN, sample;
    etc_trace_bus_t              tPinsF, tPinsFN;
    logic                        outEn, outEnT, onS, onT, calS, calT;
    logic                        outEnF, onF, calF;
    logic [BANK_W-1:0]           bankS, bankT, bankF;
    logic [15:0]                 clkEdges;
    int                          n_errors = 0;
    int                          samples_checked = 0;

    etc_trace_core #(.CAPTURE_MODE(CAP_STATE), .TDM_RATE(2), .DRIVER_TYPE(DRV_DIFF)) dut (
        .sys_clk(sys_clk), .rst_b(rst_b), .bankData(bankData), .ctrlLink(ctrlLink),
        .tracePins(tracePins), .tracePinsN(tracePinsN), .traceOutEn(outEn),
        .activeBank(bankS), .outputsOn(onS), .calibrating(calS));
    // The second build shares the control link, so every frame also probes its refusal.
    etc_trace_core #(.CAPTURE_MODE(CAP_TIMING), .ALWAYS_ON(1'b1)) dutT (
        .sys_clk(sys_clk), .rst_b(rst_b), .bankData(bankDataT), .ctrlLink(ctrlLink),
        .tracePins(tPinsT), .tracePinsN(tPinsTN), .traceOutEn(outEnT),
        .activeBank(bankT), .outputsOn(onT), .calibrating(calT));
    // A single-rate, falling-edge build without auto setup listens to the same control link.
    etc_trace_core #(.CAPTURE_MODE(CAP_STATE), .TDM_RATE(1), .CLOCK_EDGE(EDGE_FALLING),
        .AUTO_SETUP(1'b0)) dutF (
        .sys_clk(sys_clk), .rst_b(rst_b), .bankData(bankDataF), .ctrlLink(ctrlLink),
        .tracePins(tPinsF), .tracePinsN(tPinsFN), .traceOutEn(outEnF),
        .activeBank(bankF), .outputsOn(onF), .calibrating(calF));
    etc_analyzer_model ana (.sys_clk(sys_clk), .rst_b(rst_b), .tracePins(tracePins),
        .traceOutEn(outEn), .sample(sample), .clkEdges(clkEdges));

    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
        samples_checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED at %0t: %s", $time, what);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    // The link clock only runs inside a frame, 100 ns high and 100 ns low.
    task automatic sendFrame(input logic [7:0] cmd, input int nBits);
        ctrlLink.sel = 1'b1;
        tick(4);
        for (int i = 7; i > 7 - nBits; i--) begin
            ctrlLink.data = cmd[i];
            #100 ctrlLink.clk = 1'b1;
            #100 ctrlLink.clk = 1'b0;
        end
        ctrlLink.sel  = 1'b0;
        ctrlLink.data = 1'b0;
        tick(6);
    endtask

    task automatic testReset();
        check(16'({onS, outEn, calS, bankS}), 16'h0000, "idle after reset");
        check(16'(tracePins), 16'h0000, "pins quiet after reset");
        check(16'({onT, outEnT, bankT}), 16'h000C, "always-on live on bank 0");
        check(16'({onF, calF, bankF, tPinsF}), 16'h0000, "falling edge build idle");
        check(16'(tPinsT), 16'(bankDataT[0]), "bank 0 on pins");
    endtask

    task automatic testBanks();
        for (int b = 0; b < BANK_COUNT; b++) begin
            sendFrame(8'h80 | 8'(b), 8);
            check(16'({outEn, bankS}), 16'(4 + b), "bank select");
            check(16'({outEnF, bankF}), 16'(4 + b), "falling edge bank select");
        end
        sendFrame(8'h85, 8);
        check(16'(bankS), 16'h0003, "out of range bank");
        sendFrame(8'h81, 7);
        check(16'(bankS), 16'h0003, "short frame");
        check(16'({onT, bankT, calT}), 16'h0008, "always-on ignores commands");
    endtask

    task automatic testStateData();
        logic [15:0] e0;
        logic        lo, hi, bad, ck;
        lo = 1'b0;
        hi = 1'b0;
        bad = 1'b0;
        sendFrame(8'h82, 8);
        tick(4);
        e0 = clkEdges;
        ck = tPinsF.traceClockPin;
        for (int i = 0; i < 8; i++) begin
            tick(1);
            if (sample.traceDataPins === 8'hC3) lo = 1'b1;
            else if (sample.traceDataPins === 8'hA5) hi = 1'b1;
            else bad = 1'b1;
            check(16'(tPinsF.traceDataPins), 16'h003C, "1x word on every cycle");
            check(16'(tPinsF.traceClockPin), 16'(!ck), "1x clock pin toggles");
            ck = tPinsF.traceClockPin;
        end
        check(16'({lo, hi, bad}), 16'h0006, "both halves of the word");
        check(clkEdges - e0, 16'h0008, "clock pin toggles");
        check(16'(tracePinsN ^ tracePins), 16'h01FF, "differential leg");
        check(16'(tPinsTN), 16'h0000, "single-ended leg");
        check(16'(tPinsFN), 16'h0000, "single-ended leg at 1x");
        bankData[2] = 16'h5A3C;
        #2;
        check(16'(tracePins.traceDataPins inside {8'hC3, 8'hA5}), 16'h0001, "pipelined");
        tick(1);
        bankData[2] = 16'hA5C3;
    endtask

    task automatic testTiming();
        tick(1);
        bankDataT[0] = 9'h0F0;
        #2;
        check(16'(tPinsT), 16'h00F0, "combinational path");
        tick(1);
        bankDataT[0] = 9'h155;
        #2;
        check(16'(tPinsT), 16'h0155, "clock pin carries data");
        tick(1);
    endtask

    task automatic testCal();
        logic [7:0] prev;
        sendFrame(8'hC2, 8);
        check(16'(calS), 16'h0001, "calibration on");
        check(16'({onF, calF}), 16'h0002, "no calibration without auto setup");
        prev = tracePins.traceDataPins;
        for (int i = 0; i < 8; i++) begin
            tick(1);
            check(16'($onehot(tracePins.traceDataPins)), 16'h0001, "walking one");
            check(16'(tracePins.traceDataPins), 16'({prev[6:0], prev[7]}), "one pin a cycle");
            prev = tracePins.traceDataPins;
        end
        sendFrame(8'h00, 8);
        check(16'({onS, outEn, calS}), 16'h0000, "disabled");
        check(16'(tracePins), 16'h0000, "pins quiet when disabled");
    endtask

    task automatic print_verdict();
        $display("Checks made: %0d, mismatches: %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    initial begin
        #500_000;
        n_errors++;
        $display("CHECK FAILED at %0t: watchdog expired", $time);
        print_verdict();
    end

    initial begin
        rst_b = 1'b0;
        ctrlLink = '0;
        bankData = '0;
        bankData[1] = 16'h1234;
        bankData[2] = 16'hA5C3;
        bankDataT = '0;
        bankDataT[0] = 9'h155;
        bankDataT[1] = 9'h0AA;
        bankDataF = '0;
        bankDataF[2] = 8'h3C;
        repeat (6) @(posedge sys_clk);
        #1 rst_b = 1'b1;
        tick(3);
        testReset();
        testBanks();
        testStateData();
        testTiming();
        testCal();
        print_verdict();
    end
endmodule
`default_nettype wire

// ---- verilog/etc_pkg.sv ----
// Shared constants, modes and pin carriers for the external trace output core.
package etc_pkg;

    // Trace data pin count; legal builds span 4 through 128 pins.
    localparam int PIN_COUNT    = 8;
    // Signal bank count; a power of two from 1 through 64.
    localparam int BANK_COUNT   = 4;
    localparam int BANK_W       = (BANK_COUNT > 1) ? $clog2(BANK_COUNT) : 1;
    localparam int MAX_BANKS    = 64;
    localparam int MIN_PINS     = 4;
    localparam int MAX_PINS     = 128;

    // Control port command word, shifted in most significant bit first.
    localparam int CMD_BITS     = 8;
    localparam int CMD_EN_BIT   = 7;
    localparam int CMD_CAL_BIT  = 6;
    localparam int CMD_BANK_LSB = 0;
    localparam int CMD_BANK_W   = 6;
    localparam int CNT_W        = 4;
    localparam int CNT_LIMIT    = CMD_BITS + 1;

    // Calibration walking-one position counter.
    localparam int CAL_POS_W    = 7;

    // Reset values.
    localparam logic [BANK_W-1:0] BANK_RESET = BANK_W'(0);
    localparam logic              CAL_RESET  = 1'b0;

    typedef enum logic {
        CAP_STATE,
        CAP_TIMING
    } etc_capture_t;

    typedef enum logic {
        DRV_SINGLE,
        DRV_DIFF
    } etc_driver_t;

    typedef enum logic {
        EDGE_RISING,
        EDGE_FALLING
    } etc_edge_t;

    // Serial control link from the debug controller core.
    typedef struct packed {
        logic clk;
        logic sel;
        logic data;
    } etc_ctrl_link_t;

    // One side of the trace pin group: clock pin plus data pins.
    typedef struct packed {
        logic                 traceClockPin;
        logic [PIN_COUNT-1:0] traceDataPins;
    } etc_trace_bus_t;

endpackage

// ---- verilog/etc_sync.sv ----
// Two-stage synchroniser for levels that arrive from outside the core clock domain.
`timescale 1ns/1ps
`default_nettype none
module etc_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk,
    input  wire logic             rst_b,
    input  wire logic [WIDTH-1:0] asyncIn,
    output logic      [WIDTH-1:0] syncOut
);
    import etc_pkg::*;

    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } etc_sync_state_t;

    etc_sync_state_t state_reg;
    etc_sync_state_t state_next;

    // The first stage feeds only the second stage, never any logic.
    always_comb begin
        state_next.meta   = asyncIn;
        state_next.stable = state_reg.meta;
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign syncOut = state_reg.stable;

endmodule
`default_nettype wire

// ---- verilog/etc_trace_core.sv ----
// External trace output core: bank multiplexer, pin pipeline and control port.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Run-time bank multiplexer, one of N ports
// - Pins run at 1x or 2x port rate
// - Double rate allowed only in State mode
// - Trace data pin count from 4 to 128
// - State mode port width is pins times rate
// - Timing mode port width adds clock pin
// - Clock pin clocks in State, data in Timing
// - Always-on keeps logic and drivers enabled
// - Always-on selects bank 0 after configuration
// - Always-on default off, Timing mode only
// - One driver type for all trace pins
// - Auto setup gives pin mapping and calibration
// - State mode pipelined, Timing mode combinational
// - Selectable capture edge also clocks calibration
module etc_trace_core #(
    parameter etc_pkg::etc_capture_t CAPTURE_MODE  = etc_pkg::CAP_STATE,
    parameter int                    TDM_RATE      = 1,
    parameter bit                    ALWAYS_ON     = 1'b0,
    parameter etc_pkg::etc_edge_t    CLOCK_EDGE    = etc_pkg::EDGE_RISING,
    parameter etc_pkg::etc_driver_t  DRIVER_TYPE   = etc_pkg::DRV_SINGLE,
    parameter bit                    AUTO_SETUP    = 1'b1,
    localparam bit                   TIMING        = (CAPTURE_MODE == etc_pkg::CAP_TIMING),
    localparam int                   TDM_EFF       = TIMING ? 1 : ((TDM_RATE == 2) ? 2 : 1),
    localparam bit                   ALWAYS_ON_EFF = ALWAYS_ON && TIMING,
    localparam int                   PORT_W        = (etc_pkg::PIN_COUNT + (TIMING ? 1 : 0))
                                                     * TDM_EFF
) (
    input  wire logic                                        sys_clk,
    input  wire logic                                        rst_b,
    input  wire logic [etc_pkg::BANK_COUNT-1:0][PORT_W-1:0] bankData,
    input  wire etc_pkg::etc_ctrl_link_t                     ctrlLink,
    output etc_pkg::etc_trace_bus_t                          tracePins,
    output etc_pkg::etc_trace_bus_t                          tracePinsN,
    output logic                                             traceOutEn,
    output logic [etc_pkg::BANK_W-1:0]                       activeBank,
    output logic                                             outputsOn,
    output logic                                             calibrating
);
    import etc_pkg::*;

    localparam int CAP_W = 2 * PIN_COUNT;

    typedef struct packed {
        logic                 linkClkPrev;
        logic                 linkSelPrev;
        logic [CMD_BITS-1:0]  shift;
        logic [CNT_W-1:0]     bitCnt;
        logic [BANK_W-1:0]    bank;
        logic                 outOn;
        logic                 cal;
        logic                 phase;
        logic [CAP_W-1:0]     capWord;
        logic [PIN_COUNT-1:0] dataOut;
        logic                 clkOut;
        logic [CAL_POS_W-1:0] calPos;
    } etc_core_state_t;

    // Always-on builds come up driving bank 0 with no controller setup.
    localparam etc_core_state_t STATE_RESET = '{
        outOn:   ALWAYS_ON_EFF,
        bank:    BANK_RESET,
        cal:     CAL_RESET,
        default: '0
    };

    etc_core_state_t      state_reg;
    etc_core_state_t      state_next;
    logic                 capClk;
    etc_ctrl_link_t       linkSync;
    logic                 clkRise;
    logic                 frameEnd;
    logic                 cmdValid;
    logic [CMD_BANK_W-1:0] cmdBankField;
    logic [PORT_W-1:0]    selWord;
    logic [PIN_COUNT-1:0] selLo;
    logic [PIN_COUNT-1:0] selHi;

    function automatic logic [PIN_COUNT-1:0] pinOneHot(input logic [CAL_POS_W-1:0] pos);
        pinOneHot = PIN_COUNT'(1) << pos;
    endfunction

    // The capture edge is chosen by inverting the clock once, so every register
    // below, calibration included, shares the same edge.
    assign capClk = sys_clk ^ (CLOCK_EDGE == EDGE_FALLING);

    // The control link comes from another clock, so it is synchronised first.
    etc_sync #(
        .WIDTH(3)
    ) u_link_sync (
        .clk     (capClk),
        .rst_b   (rst_b),
        .asyncIn (ctrlLink),
        .syncOut (linkSync)
    );

    assign clkRise      = linkSync.clk && !state_reg.linkClkPrev;
    assign frameEnd     = !linkSync.sel && state_reg.linkSelPrev;
    assign cmdBankField = state_reg.shift[CMD_BANK_LSB +: CMD_BANK_W];
    // Commands naming a bank that was not built are dropped whole.
    assign cmdValid     = frameEnd && (state_reg.bitCnt == CNT_W'(CMD_BITS))
                          && (cmdBankField < BANK_COUNT) && !ALWAYS_ON_EFF;

    assign selWord = bankData[state_reg.bank];
    assign selLo   = selWord[PIN_COUNT-1:0];
    assign selHi   = PIN_COUNT'(CAP_W'(selWord) >> PIN_COUNT);

    always_comb begin
        state_next             = state_reg;
        state_next.linkClkPrev = linkSync.clk;
        state_next.linkSelPrev = linkSync.sel;

        if (linkSync.sel) begin
            if (clkRise && (state_reg.bitCnt != CNT_W'(CNT_LIMIT))) begin
                state_next.shift  = {state_reg.shift[CMD_BITS-2:0], linkSync.data};
                state_next.bitCnt = state_reg.bitCnt + CNT_W'(1);
            end
        end else begin
            state_next.bitCnt = '0;
        end

        if (cmdValid) begin
            state_next.outOn = state_reg.shift[CMD_EN_BIT];
            state_next.cal   = AUTO_SETUP && state_reg.shift[CMD_CAL_BIT];
            state_next.bank  = BANK_W'(cmdBankField);
        end

        // Ports are sampled on phase 0 and shown on the pins two and three cycles later.
        state_next.phase = !state_reg.phase;
        if (!state_reg.phase) begin
            state_next.capWord = CAP_W'(selWord);
        end

        // At double rate the low half leaves first, then the high half.
        if (state_reg.cal) begin
            state_next.dataOut = pinOneHot(state_reg.calPos);
        end else if ((TDM_EFF == 2) && !state_reg.phase) begin
            state_next.dataOut = state_reg.capWord[CAP_W-1:PIN_COUNT];
        end else begin
            state_next.dataOut = state_reg.capWord[PIN_COUNT-1:0];
        end

        // At 1x the clock rises mid-window; at 2x it toggles with each half and
        // the analyzer places its sampling point through auto setup.
        state_next.clkOut = state_reg.phase ^ (TDM_EFF == 1);

        if (state_reg.cal) begin
            if (state_reg.calPos == CAL_POS_W'(PIN_COUNT - 1)) begin
                state_next.calPos = '0;
            end else begin
                state_next.calPos = state_reg.calPos + CAL_POS_W'(1);
            end
        end else begin
            state_next.calPos = '0;
        end
    end

    always_ff @(posedge capClk or negedge rst_b) begin
        if (!rst_b) begin
            state_reg <= STATE_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    generate
        if (TIMING) begin : g_timing
            // Timing mode keeps no flops between the ports and the pins.
            always_comb begin
                if (!state_reg.outOn) begin
                    tracePins = '0;
                end else if (state_reg.cal) begin
                    tracePins = {state_reg.clkOut, state_reg.dataOut};
                end else begin
                    tracePins = {selWord[PIN_COUNT], selLo};
                end
            end
        end else begin : g_state
            always_comb begin
                if (!state_reg.outOn) begin
                    tracePins = '0;
                end else begin
                    tracePins = {state_reg.clkOut, state_reg.dataOut};
                end
            end
        end
    endgenerate

    // Both legs of every pin share one driver type.
    genvar gPin;
    generate
        for (gPin = 0; gPin < PIN_COUNT; gPin++) begin : g_neg_leg
            assign tracePinsN.traceDataPins[gPin] = (DRIVER_TYPE == DRV_DIFF) && state_reg.outOn
                                                   && !tracePins.traceDataPins[gPin];
        end
    endgenerate
    assign tracePinsN.traceClockPin = (DRIVER_TYPE == DRV_DIFF) && state_reg.outOn
                                      && !tracePins.traceClockPin;

    assign traceOutEn  = state_reg.outOn;
    assign activeBank  = state_reg.bank;
    assign outputsOn   = state_reg.outOn;
    assign calibrating = state_reg.cal;

    default clocking cbChk @(posedge capClk);
    endclocking
    default disable iff (!rst_b);

    logic running;
    assign running = state_reg.outOn && !state_reg.cal;

    chk_bank_in_range: assert property (activeBank < BANK_COUNT)
        else $error("Selected bank beyond built bank count.");

    // The package sizes are checked here so that an illegal build shows up on the first run.
    chk_build_sizes: assert property (
        PIN_COUNT >= MIN_PINS && PIN_COUNT <= MAX_PINS && BANK_COUNT <= MAX_BANKS
        && (BANK_COUNT & (BANK_COUNT - 1)) == 0)
        else $error("Pin or bank count outside the legal build range.");

    chk_always_drive: assert property (ALWAYS_ON_EFF |-> traceOutEn && !calibrating)
        else $error("Always-on core not driving its pins.");

    chk_always_bank: assert property (ALWAYS_ON_EFF |-> activeBank == BANK_RESET)
        else $error("Always-on core left bank zero.");

    chk_timing_comb: assert property (
        TIMING && running |-> tracePins == {selWord[PORT_W-1], selLo})
        else $error("Timing mode pins differ from selected port.");

    chk_state_lo_half: assert property (
        !TIMING && running && !state_reg.phase ##1 running ##1 running
        |-> tracePins.traceDataPins == $past(selLo, 2))
        else $error("State mode pins lost the low half of the port.");

    chk_state_hi_half: assert property (
        !TIMING && (TDM_EFF == 2) && running && !state_reg.phase ##1 running [*3]
        |-> tracePins.traceDataPins == $past(selHi, 3))
        else $error("Double rate pins lost the high half of the port.");

    chk_clock_toggle: assert property (
        !TIMING && running ##1 running
        |-> tracePins.traceClockPin != $past(tracePins.traceClockPin))
        else $error("State mode trace clock did not toggle.");

    chk_diff_pair: assert property (
        (DRIVER_TYPE == DRV_DIFF) && traceOutEn
        |-> tracePinsN == ~tracePins)
        else $error("Negative legs do not mirror the pins.");

    chk_cmd_apply: assert property (
        cmdValid |=> outputsOn == $past(state_reg.shift[CMD_EN_BIT])
                     && activeBank == $past(BANK_W'(cmdBankField)))
        else $error("Controller command not applied next cycle.");

    chk_cal_walk: assert property (
        calibrating && outputsOn ##1 calibrating && outputsOn
        |-> tracePins.traceDataPins == pinOneHot($past(state_reg.calPos)))
        else $error("Calibration pattern is not a walking one.");

    cov_cmd_taken: cover property (cmdValid);
    cov_bank_switch: cover property (cmdValid ##1 activeBank != BANK_RESET);
    cov_cal_run: cover property (calibrating && outputsOn ##1 calibrating [*3]);
    cov_stream: cover property (running [*4]);

endmodule
`default_nettype wire
